// ---- hdl/ref_monitor_sticky_flags.sv ----
`timescale 1ns/1ps
// Function
// - bit 4 latches a period or frequency failure until the host acknowledges it.
// - bit 3 latches a guard timer failure until the host acknowledges it.
// - bit 2 latches a coarse frequency failure until the host acknowledges it.
// - bit 1 latches a single cycle failure until the host acknowledges it.
// - bit 0 latches a loss of signal until the host acknowledges it.
// - references 1 to 5 follow reference 0 at consecutive addresses, same layout, bits 7:5 reserved.
// - while the lock register is non-zero the monitor cannot update any flag.
module ref_monitor_sticky_flags #(
  parameter int NUM_REFS = mon_sticky_pkg::NUM_REFS
) (
  // clock and reset
  input  wire logic                              i_core_clk,
  input  wire logic                              i_sys_rst,
  // host register port
  input  wire mon_sticky_pkg::host_req_t         i_host_req,
  output logic [mon_sticky_pkg::DATA_W-1:0]      o_rdata,
  // monitor processor events, one-cycle pulses
  input  wire mon_sticky_pkg::fail_flags_t [NUM_REFS-1:0] i_mon_fail,
  output logic                                   o_update_blocked,
  // status outputs
  output mon_sticky_pkg::fail_flags_t [NUM_REFS-1:0] o_ref_flags,
  output logic                                   o_irq
);

  localparam int DW = mon_sticky_pkg::DATA_W;
  localparam int AW = mon_sticky_pkg::ADDR_W;

  typedef struct packed {
    logic [DW-1:0]       lock;
    logic [NUM_REFS-1:0] irq_status;
    logic [NUM_REFS-1:0] irq_enable;
    logic [DW-1:0]       rdata;
  } state_t;

  state_t                                     st_r;
  state_t                                     st_nxt;
  mon_sticky_pkg::fail_flags_t [NUM_REFS-1:0] flags;
  logic [NUM_REFS-1:0]                        new_fail;
  logic [NUM_REFS-1:0]                        flag_wr;
  logic                                       set_allow;
  logic [mon_sticky_pkg::ADDR_W-1:0]          ref_index;
  logic                                       ref_hit;
  mon_sticky_pkg::fail_flags_t                host_keep;

  // field layout of a flag register on the host port
  function automatic logic [DW-1:0] pack_flags(
    input mon_sticky_pkg::fail_flags_t f
  );
    logic [DW-1:0] v;
    v = '0;
    v[mon_sticky_pkg::PFM_BIT] = f.pfm;
    v[mon_sticky_pkg::GST_BIT] = f.gst;
    v[mon_sticky_pkg::CFM_BIT] = f.cfm;
    v[mon_sticky_pkg::SCM_BIT] = f.scm;
    v[mon_sticky_pkg::LOS_BIT] = f.los;
    return v;
  endfunction : pack_flags

  function automatic mon_sticky_pkg::fail_flags_t unpack_flags(
    input logic [DW-1:0] v
  );
    mon_sticky_pkg::fail_flags_t f;
    f.pfm = v[mon_sticky_pkg::PFM_BIT];
    f.gst = v[mon_sticky_pkg::GST_BIT];
    f.cfm = v[mon_sticky_pkg::CFM_BIT];
    f.scm = v[mon_sticky_pkg::SCM_BIT];
    f.los = v[mon_sticky_pkg::LOS_BIT];
    return f;
  endfunction : unpack_flags

  // any non-zero lock freezes monitor updates, events meanwhile are dropped
  assign set_allow        = (st_r.lock == mon_sticky_pkg::LOCK_RST);
  assign o_update_blocked = ~set_allow;

  // flag registers sit at consecutive addresses from reference 0
  assign ref_index = i_host_req.addr - mon_sticky_pkg::REF0_FLAGS_ADDR;
  assign ref_hit   = (i_host_req.addr >= mon_sticky_pkg::REF0_FLAGS_ADDR)
                  && (ref_index < AW'(NUM_REFS));
  // reserved bits 7:5 have no storage behind them
  assign host_keep = unpack_flags(i_host_req.wdata);

  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++) begin : g_ref
      assign flag_wr[g] = i_host_req.wr && ref_hit
        && (ref_index == AW'(g));
      ref_fail_sticky u_sticky (
        .i_core_clk  (i_core_clk),
        .i_sys_rst   (i_sys_rst),
        .i_fail_set  (i_mon_fail[g]),
        .i_set_allow (set_allow),
        .i_host_wr   (flag_wr[g]),
        .i_host_keep (host_keep),
        .o_flags     (flags[g]),
        .o_new_fail  (new_fail[g])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    // host writes
    if (i_host_req.wr) begin
      if (i_host_req.addr == mon_sticky_pkg::STICKY_LOCK_ADDR) begin
        st_nxt.lock = i_host_req.wdata;
      end else if (i_host_req.addr == mon_sticky_pkg::IRQ_ENABLE_ADDR) begin
        st_nxt.irq_enable = i_host_req.wdata[NUM_REFS-1:0];
      end else if (i_host_req.addr == mon_sticky_pkg::IRQ_CLEAR_ADDR) begin
        st_nxt.irq_status = st_r.irq_status
                          & ~i_host_req.wdata[NUM_REFS-1:0];
      end
    end
    // newly latched failures win over a same-cycle clear
    st_nxt.irq_status = st_nxt.irq_status | new_fail;
    // read data stand only in the cycle after the strobe
    st_nxt.rdata = mon_sticky_pkg::RDATA_IDLE;
    if (i_host_req.rd) begin
      if (ref_hit) begin
        st_nxt.rdata = pack_flags(flags[ref_index[2:0]]);
      end else if (i_host_req.addr == mon_sticky_pkg::STICKY_LOCK_ADDR) begin
        st_nxt.rdata = st_r.lock;
      end else if (i_host_req.addr == mon_sticky_pkg::IRQ_STATUS_ADDR) begin
        st_nxt.rdata = DW'(st_r.irq_status);
      end else if (i_host_req.addr == mon_sticky_pkg::IRQ_ENABLE_ADDR) begin
        st_nxt.rdata = DW'(st_r.irq_enable);
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r.lock       <= mon_sticky_pkg::LOCK_RST;
      st_r.irq_status <= mon_sticky_pkg::IRQ_STATUS_RST;
      st_r.irq_enable <= mon_sticky_pkg::IRQ_ENABLE_RST;
      st_r.rdata      <= mon_sticky_pkg::RDATA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata     = st_r.rdata;
  assign o_ref_flags = flags;
  assign o_irq       = |(st_r.irq_status & st_r.irq_enable);

endmodule : ref_monitor_sticky_flags

// ---- hdl/mon_sticky_pkg.sv ----
package mon_sticky_pkg;

  // bank geometry
  localparam int NUM_REFS = 6;
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 8;
  localparam int FLAG_W   = 5;

  // per-reference failure flag registers
  localparam logic [ADDR_W-1:0] REF0_FLAGS_ADDR = 16'h0186;
  localparam logic [ADDR_W-1:0] REF1_FLAGS_ADDR = 16'h0187;
  localparam logic [ADDR_W-1:0] REF2_FLAGS_ADDR = 16'h0188;
  localparam logic [ADDR_W-1:0] REF3_FLAGS_ADDR = 16'h0189;
  localparam logic [ADDR_W-1:0] REF4_FLAGS_ADDR = 16'h018A;
  localparam logic [ADDR_W-1:0] REF5_FLAGS_ADDR = 16'h018B;

  // lock and interrupt registers
  localparam logic [ADDR_W-1:0] STICKY_LOCK_ADDR = 16'h01A0;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR  = 16'h01A1;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR   = 16'h01A2;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR  = 16'h01A3;

  // flag field positions
  localparam int PFM_BIT = 4;
  localparam int GST_BIT = 3;
  localparam int CFM_BIT = 2;
  localparam int SCM_BIT = 1;
  localparam int LOS_BIT = 0;

  // reset values
  localparam logic [FLAG_W-1:0]   FLAGS_RST      = 5'h00;
  localparam logic [DATA_W-1:0]   LOCK_RST       = 8'h00;
  localparam logic [NUM_REFS-1:0] IRQ_STATUS_RST = 6'h00;
  localparam logic [NUM_REFS-1:0] IRQ_ENABLE_RST = 6'h00;
  localparam logic [DATA_W-1:0]   RDATA_IDLE     = 8'h00;

  // one reference's failure flags, msb first matches the bit positions
  typedef struct packed {
    logic pfm;
    logic gst;
    logic cfm;
    logic scm;
    logic los;
  } fail_flags_t;

  // host register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } host_req_t;

endpackage : mon_sticky_pkg

// ---- hdl/ref_fail_sticky.sv ----
`timescale 1ns/1ps
module ref_fail_sticky (
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_sys_rst,
  // monitor side
  input  wire mon_sticky_pkg::fail_flags_t i_fail_set,
  input  wire logic                  i_set_allow,
  // host side
  input  wire logic                  i_host_wr,
  input  wire mon_sticky_pkg::fail_flags_t i_host_keep,
  // outputs
  output mon_sticky_pkg::fail_flags_t o_flags,
  output logic                       o_new_fail
);

  typedef struct packed {
    mon_sticky_pkg::fail_flags_t flags;
  } state_t;

  state_t                      st_r;
  state_t                      st_nxt;
  mon_sticky_pkg::fail_flags_t keep;
  mon_sticky_pkg::fail_flags_t set;

  always_comb begin
    st_nxt = st_r;
    // zero acknowledges, one leaves the flag alone
    keep = i_host_wr ? (st_r.flags & i_host_keep) : st_r.flags;
    set  = i_set_allow ? i_fail_set : mon_sticky_pkg::fail_flags_t'(0);
    // a failure in the clearing cycle survives: set beats clear
    st_nxt.flags.pfm = keep.pfm | set.pfm;
    st_nxt.flags.gst = keep.gst | set.gst;
    st_nxt.flags.cfm = keep.cfm | set.cfm;
    st_nxt.flags.scm = keep.scm | set.scm;
    st_nxt.flags.los = keep.los | set.los;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r.flags <= mon_sticky_pkg::FLAGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_flags    = st_r.flags;
  assign o_new_fail = |(set & ~keep);

endmodule : ref_fail_sticky

// ---- dv/ref_sticky_monitor.sv ----
`timescale 1ns/1ps
module ref_sticky_monitor #(
  parameter int NUM_REFS = mon_sticky_pkg::NUM_REFS
) (
  // clock and reset
  input wire logic                                     i_core_clk,
  input wire logic                                     i_sys_rst,
  // host port
  input wire mon_sticky_pkg::host_req_t                i_host_req,
  input wire logic [mon_sticky_pkg::DATA_W-1:0]        o_rdata,
  // monitor side and status
  input wire mon_sticky_pkg::fail_flags_t [NUM_REFS-1:0] i_mon_fail,
  input wire logic                                     o_update_blocked,
  input wire mon_sticky_pkg::fail_flags_t [NUM_REFS-1:0] o_ref_flags,
  input wire logic                                     o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic [NUM_REFS*5-1:0] flg;
  logic [NUM_REFS*5-1:0] evt;
  logic [3:0]            sel;
  logic [4:0]            cur;
  logic                  in_bank;
  assign flg = o_ref_flags;
  assign evt = i_mon_fail;
  // out-of-bank indexes give x, but only behind a false in_bank
  assign sel = i_host_req.addr[3:0] - 4'h6;
  assign cur = o_ref_flags[sel];
  assign in_bank = i_host_req.addr >= mon_sticky_pkg::REF0_FLAGS_ADDR &&
                   i_host_req.addr <= mon_sticky_pkg::REF5_FLAGS_ADDR;
  a_fail_latch: assert property (
    !o_update_blocked |=> (flg & $past(evt)) == $past(evt))
    else $error("failure event not latched");
  a_flag_hold: assert property (
    !i_host_req.wr |=> (flg & $past(flg)) == $past(flg))
    else $error("flag dropped without host write");
  a_lock_freeze: assert property (
    o_update_blocked |=> (flg & ~$past(flg)) == '0)
    else $error("flag set while locked");
  a_lock_flag: assert property (
    i_host_req.wr && i_host_req.addr == mon_sticky_pkg::STICKY_LOCK_ADDR
    |=> o_update_blocked == ($past(i_host_req.wdata) != 8'h00))
    else $error("blocked flag does not follow lock");
  a_read_idle: assert property (
    !i_host_req.rd |=> o_rdata == 8'h00)
    else $error("read data outside read answer");
  a_read_flags: assert property (
    i_host_req.rd && in_bank |=> o_rdata == {3'h0, $past(cur)})
    else $error("flag read mismatch");
  a_write_clear: assert property (
    i_host_req.wr && in_bank && i_mon_fail[sel] == 5'h00
    |=> {3'h0, o_ref_flags[$past(sel)]} ==
        ({3'h0, $past(cur)} & $past(i_host_req.wdata)))
    else $error("flag write clear mismatch");
  a_irq_cause: assert property (
    $rose(o_irq) |-> $past(evt) != '0 || $past(i_host_req.wr))
    else $error("interrupt rose without cause");
endmodule : ref_sticky_monitor

// ---- dv/tb_ref_monitor_sticky_flags.sv ----
`timescale 1ns/1ps
module tb_ref_monitor_sticky_flags;
  logic                              clk = 1'b0;
  logic                              rst = 1'b1;
  mon_sticky_pkg::host_req_t         req = '0;
  mon_sticky_pkg::fail_flags_t [5:0] mon = '0;
  mon_sticky_pkg::fail_flags_t [5:0] flg;
  logic [7:0]                        rdata;
  logic                              blk;
  logic                              irq;
  logic                              rd_d = 1'b0;
  logic [4:0]                        m [6];
  logic [7:0]                        exp_q [$];
  logic [7:0]                        w;
  int fails = 0, checks_done = 0, seed = 32'h2ff2;
  ref_monitor_sticky_flags dut_u (.i_core_clk(clk), .i_sys_rst(rst),
    .i_host_req(req), .o_rdata(rdata), .i_mon_fail(mon),
    .o_update_blocked(blk), .o_ref_flags(flg), .o_irq(irq));
  initial forever #20 clk = ~clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input mon_sticky_pkg::host_req_t r, input int i,
                     input logic [4:0] f);
    mon_sticky_pkg::fail_flags_t [5:0] v;
    v = '0;
    v[i] = f;
    req <= r;
    mon <= v;
    @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc('{a, d, 1'b1, 1'b0}, 0, 5'h00);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cyc('{a, 8'h00, 1'b0, 1'b1}, 0, 5'h00);
  endtask : rd
  task automatic rd_all;
    for (int i = 0; i < 6; i++)
      rd(mon_sticky_pkg::REF0_FLAGS_ADDR + 16'(i), {3'h0, m[i]});
  endtask : rd_all
  task automatic irq_is(input logic e);
    cyc('0, 0, 5'h00);
    @(negedge clk);
    check({7'h0, irq}, {7'h0, e});
    @(posedge clk);
  endtask : irq_is
  // answer stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rd_d) check(rdata, exp_q.pop_front());
    rd_d = req.rd;
  end
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #(40 * 3000);
    fails++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) m[i] = 5'h00;
    rd_all();
    for (int i = 0; i < 6; i++) begin
      w = 8'($random(seed));
      m[i] = w[4:0] | 5'(1 << (i % 5));
      cyc('0, i, m[i]);
    end
    rd_all();
    for (int i = 0; i < 6; i++) begin
      w = 8'($random(seed));
      wr(mon_sticky_pkg::REF0_FLAGS_ADDR + 16'(i), w);
      m[i] &= w[4:0];
    end
    rd_all();
    // lock, clear, unlock, read; events during lock are lost
    wr(mon_sticky_pkg::STICKY_LOCK_ADDR, 8'h5A);
    cyc('0, 2, 5'h1F);
    wr(mon_sticky_pkg::REF0_FLAGS_ADDR, 8'hE0);
    m[0] = 5'h00;
    rd(mon_sticky_pkg::STICKY_LOCK_ADDR, 8'h5A);
    wr(mon_sticky_pkg::STICKY_LOCK_ADDR, 8'h00);
    rd_all();
    for (int i = 0; i < 6; i++) begin
      wr(mon_sticky_pkg::REF0_FLAGS_ADDR + 16'(i), 8'h00);
      m[i] = 5'h00;
    end
    wr(mon_sticky_pkg::IRQ_CLEAR_ADDR, 8'h3F);
    wr(mon_sticky_pkg::IRQ_ENABLE_ADDR, 8'h02);
    irq_is(1'b0);
    cyc('0, 3, 5'h04);
    m[3] = 5'h04;
    rd(mon_sticky_pkg::IRQ_STATUS_ADDR, 8'h08);
    irq_is(1'b0);
    cyc('0, 1, 5'h10);
    m[1] = 5'h10;
    irq_is(1'b1);
    rd(mon_sticky_pkg::IRQ_ENABLE_ADDR, 8'h02);
    rd(mon_sticky_pkg::IRQ_CLEAR_ADDR, 8'h00);
    wr(16'h0190, 8'hFF);
    rd(16'h0190, 8'h00);
    wr(mon_sticky_pkg::IRQ_CLEAR_ADDR, 8'h02);
    irq_is(1'b0);
    // status is read-only, a write must leave it alone
    wr(mon_sticky_pkg::IRQ_STATUS_ADDR, 8'h00);
    rd(mon_sticky_pkg::IRQ_STATUS_ADDR, 8'h08);
    // a failure in the clearing cycle must survive the clear
    cyc('{mon_sticky_pkg::REF4_FLAGS_ADDR, 8'h00, 1'b1, 1'b0}, 4, 5'h01);
    m[4] = 5'h01;
    rd_all();
    cyc('0, 0, 5'h00);
    cyc('0, 0, 5'h00);
    final_report();
  end
endmodule : tb_ref_monitor_sticky_flags
bind ref_monitor_sticky_flags ref_sticky_monitor #(.NUM_REFS(NUM_REFS))
  mon_u (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_host_req(i_host_req), .o_rdata(o_rdata), .i_mon_fail(i_mon_fail),
  .o_update_blocked(o_update_blocked), .o_ref_flags(o_ref_flags),
  .o_irq(o_irq));
